// ---- pkg/ccu4_regs.svh ----
// Register offsets, bit positions and reset values of the channel-four compare unit
`ifndef CCU4_REGS_SVH
`define CCU4_REGS_SVH
`define CCU4_ADDR_CFG 8'hC9
`define CCU4_ADDR_CMPL 8'hCA
`define CCU4_ADDR_CMPH 8'hCB
`define CCU4_RD_NONE 8'h00
`define CCU4_CFG_RST 8'h00
`define CCU4_CMP_RST 16'h0000
`define CCU4_P5_RST 8'h00
`define CCU4_BIT_LO 0
`define CCU4_BIT_CHAN_FOUR_MODE_SELECT 1
`endif

// ---- pkg/ccu4_pkg.sv ----
// Types shared by the channel-four compare unit
package ccu4_pkg;
   typedef enum logic [1:0] {
      CCU4_CC_OFF = 2'h0,
      CCU4_CAP_PIN = 2'h1,
      CCU4_CMP_ON = 2'h2,
      CCU4_CAP_WR = 2'h3
   } ccu4_cc_mode_t;

   // Layout of compare4_config, msb first
   typedef struct packed {
      logic port5_mode_select_hi;
      logic [2:0] port5_count;
      ccu4_cc_mode_t cc_mode;
      logic chan_four_mode_select;
      logic port5_mode_select_lo;
   } ccu4_cfg_t;

   // Output lines driven by the channel
   typedef struct packed {
      logic cc4_pin;
      logic [7:0] port5_val;
      logic [7:0] port5_sel;
   } ccu4_pins_t;
endpackage : ccu4_pkg

// ---- rtl/ccu4_compare.sv ----
// Channel-four compare/capture unit with concurrent compare onto port 5
// How it works
// - The compare register is matched only against the timer 2 count.
// - Channel four has all compare behaviours and its own config register.
// - Mode-select bit 1 gives compare mode 1, bit 0 gives mode 0.
// - Writing low port-5 select bit forces mode 1, and enables concurrent compare when the high select bit is clear.
// - A concurrent match drives a 9-bit pattern onto the pin and the connected port-5 lines (0 through n) together.
// - Mode 1 holds a preset level in a shadow latch, moved out on match.
// - A 3-bit count n connects port-5 lines 0 through n.
// - The channel-four pin is the compare output in every compare mode.
// - A two-bit field selects the compare or capture behaviour.
// - Two port-5 select bits choose concurrent compare or compare mode 2.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "ccu4_regs.svh"

module ccu4_compare
   import ccu4_pkg::*;
#(
   parameter int P5_LINES = 8,
   parameter int CMP_W = 16
) (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   input wire logic [CMP_W-1:0] timer2_count_in,
   input wire logic timer2_ovf_in,
   input wire logic p14_latch_in,
   input wire logic [P5_LINES-1:0] port5_latch_in,
   input wire logic cc4_pin_in,
   input wire logic cap_rising_in,
   output ccu4_pins_t pins_out,
   output logic port5_mode2_out
);

   ////////////////////////////////////////////////////////////////////////
   // Decode helpers

   // Count n selects lines 0..n
   function automatic logic [P5_LINES-1:0] line_mask(input logic [2:0] n);
      logic [P5_LINES-1:0] m;
      m = '0;
      for (int i = 0; i < P5_LINES; i++) begin
         m[i] = (i <= int'(n));
      end
      return m;
   endfunction : line_mask

   ////////////////////////////////////////////////////////////////////////
   // State

   ccu4_cfg_t cfg_q;
   ccu4_cfg_t cfg_d;
   logic [CMP_W-1:0] cmp_q;
   logic [CMP_W-1:0] cmp_d;
   logic [7:0] rdata_q;
   logic eq_q;
   logic shadow_q;
   logic pin_s1_q;
   logic pin_s2_q;
   logic cap_pend_q;
   ccu4_pins_t pins_q;
   ccu4_pins_t pins_d;
   logic [P5_LINES-1:0] p5_next;

   ////////////////////////////////////////////////////////////////////////
   // Register bus decode

   wire logic sel_cfg = (addr_in == `CCU4_ADDR_CFG);
   wire logic sel_cmpl = (addr_in == `CCU4_ADDR_CMPL);
   wire logic sel_cmph = (addr_in == `CCU4_ADDR_CMPH);
   wire logic wr_cfg = wr_in & sel_cfg;
   wire logic wr_cmpl = wr_in & sel_cmpl;
   wire logic wr_cmph = wr_in & sel_cmph;

   // Unmapped offsets read as zero
   wire logic [7:0] rd_mux = sel_cfg ? 8'(cfg_q) :
                             sel_cmpl ? cmp_q[7:0] :
                             sel_cmph ? cmp_q[15:8] :
                             `CCU4_RD_NONE;

   ////////////////////////////////////////////////////////////////////////
   // Mode decode

   wire logic cmp_en = (cfg_q.cc_mode == CCU4_CMP_ON);
   wire logic cap_pin_en = (cfg_q.cc_mode == CCU4_CAP_PIN);
   wire logic cap_wr_en = (cfg_q.cc_mode == CCU4_CAP_WR);
   wire logic mode1 = cfg_q.chan_four_mode_select;
   // Concurrent compare only with select bits 01; hi set means mode 2 at P5
   wire logic conc_en = cmp_en & cfg_q.port5_mode_select_lo
                        & ~cfg_q.port5_mode_select_hi;
   wire logic [P5_LINES-1:0] mask = line_mask(cfg_q.port5_count);

   ////////////////////////////////////////////////////////////////////////
   // Compare against timer 2 only

   wire logic eq = (cmp_q == timer2_count_in);
   // Edge of equality so a stalled timer fires once
   wire logic match_ev = cmp_en & eq & ~eq_q;

   ////////////////////////////////////////////////////////////////////////
   // Capture event detection

   // Pin is synchronous already; two samples give the transition
   wire logic pin_edge = cap_rising_in ? (pin_s1_q & ~pin_s2_q)
                                       : (~pin_s1_q & pin_s2_q);
   wire logic cap_req = (cap_pin_en & pin_edge) | (cap_wr_en & wr_cmpl);

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      cfg_d = cfg_q;
      if (wr_cfg) begin
         cfg_d = ccu4_cfg_t'(wdata_in);
         // Setting the low select bit forces compare mode 1
         cfg_d.chan_four_mode_select = wdata_in[`CCU4_BIT_CHAN_FOUR_MODE_SELECT]
                                       | wdata_in[`CCU4_BIT_LO];
      end
   end

   always_comb begin
      cmp_d = cmp_q;
      if (wr_cmpl) begin
         cmp_d[7:0] = wdata_in;
      end
      if (wr_cmph) begin
         cmp_d[15:8] = wdata_in;
      end
      // Capture beats a software write in the same cycle
      if (cap_pend_q) begin
         cmp_d = timer2_count_in;
      end
   end

   always_comb begin
      pins_d = pins_q;
      pins_d.port5_sel = conc_en ? mask : '0;
      // Built per line below so unselected lines never move
      pins_d.port5_val = p5_next;
      if (match_ev) begin
         // Pin follows the compare in every compare mode
         pins_d.cc4_pin = mode1 ? shadow_q : 1'b1;
      end else if (cmp_en & ~mode1 & timer2_ovf_in) begin
         pins_d.cc4_pin = 1'b0;
      end
   end

   // Each port-5 line moves only when connected and matched
   for (genvar g = 0; g < P5_LINES; g++) begin : g_p5
      wire logic upd = match_ev & conc_en & mask[g];
      assign p5_next[g] = upd ? port5_latch_in[g] : pins_q.port5_val[g];
   end

   ////////////////////////////////////////////////////////////////////////
   // Flops

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         cfg_q <= ccu4_cfg_t'(`CCU4_CFG_RST);
         cmp_q <= `CCU4_CMP_RST;
         rdata_q <= `CCU4_RD_NONE;
      end else begin
         cfg_q <= cfg_d;
         cmp_q <= cmp_d;
         // Data stands one cycle only; idle cycles return zero
         rdata_q <= rd_in ? rd_mux : `CCU4_RD_NONE;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         eq_q <= 1'b0;
         shadow_q <= 1'b0;
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         cap_pend_q <= 1'b0;
      end else begin
         eq_q <= eq;
         shadow_q <= p14_latch_in;
         pin_s1_q <= cc4_pin_in;
         pin_s2_q <= pin_s1_q;
         // Capture lands a cycle after the request, never in it
         cap_pend_q <= cap_req;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         pins_q <= '{cc4_pin: 1'b0, port5_val: `CCU4_P5_RST, port5_sel: `CCU4_P5_RST};
      end else begin
         pins_q <= pins_d;
      end
   end

   assign rdata_out = rdata_q;
   assign pins_out = pins_q;
   assign port5_mode2_out = cfg_q.port5_mode_select_hi;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (rst_in);

   sequence s_cfg_lo_write;
      wr_cfg && wdata_in[`CCU4_BIT_LO];
   endsequence

   sequence s_conc_match;
      match_ev && conc_en;
   endsequence

   sequence s_cap_write;
      wr_cmpl && cap_wr_en;
   endsequence

   sequence s_pin_edge;
      cap_pin_en && pin_edge;
   endsequence

   a_chan_four_mode_select_forced: assert property (s_cfg_lo_write |=>
      cfg_q.chan_four_mode_select)
      else $error("mode 1 not forced by low select bit");

   a_mode1_transfer: assert property (match_ev && mode1 |=>
      pins_out.cc4_pin == $past(shadow_q))
      else $error("shadow level not moved to pin");

   a_mode0_set: assert property (match_ev && !mode1 |=> ##1
      $past(pins_out.cc4_pin) == 1'b1)
      else $error("mode 0 match did not set pin");

   a_conc_pattern: assert property (s_conc_match |=>
      ((pins_out.port5_val ^ $past(port5_latch_in)) & $past(mask)) == '0)
      else $error("pattern not driven on selected lines");

   a_beyond_hold: assert property (s_conc_match |=>
      ((pins_out.port5_val ^ $past(pins_out.port5_val)) & ~$past(mask)) == '0)
      else $error("unselected port line changed");

   a_sel_width: assert property (conc_en |=>
      pins_out.port5_sel == line_mask($past(cfg_q.port5_count)))
      else $error("port line selection wrong");

   a_disabled_quiet: assert property (!cmp_en |=>
      $stable(pins_out.cc4_pin) && $stable(pins_out.port5_val))
      else $error("outputs moved while compare disabled");

   a_cap_write: assert property (s_cap_write |=> ##1
      cmp_q == $past(timer2_count_in))
      else $error("write capture did not latch timer");

   // Port lines may only move on a fresh equality with timer 2
   a_timer2_only: assert property ($changed(pins_out.port5_val) |->
      $past(eq && !eq_q))
      else $error("port lines moved without a timer 2 match");

   a_read_data: assert property (rd_in && sel_cfg |=>
      rdata_out == 8'($past(cfg_q)))
      else $error("config read back wrong");

   a_read_idle: assert property (!rd_in |=>
      rdata_out == `CCU4_RD_NONE)
      else $error("read data not zero outside a read");

   a_cmp_write: assert property (wr_cmph && !cap_pend_q |=>
      cmp_q[15:8] == $past(wdata_in))
      else $error("compare high byte not written");

   a_mode0_clear: assert property (cmp_en && !mode1 && timer2_ovf_in && !match_ev |=>
      !pins_out.cc4_pin)
      else $error("mode 0 overflow did not clear pin");

   // Mode 1 has no overflow clear, so only a match may move the pin
   a_mode1_hold: assert property (cmp_en && mode1 && !match_ev |=>
      $stable(pins_out.cc4_pin))
      else $error("mode 1 pin moved without a match");

   a_sel_off: assert property (!conc_en |=>
      pins_out.port5_sel == '0)
      else $error("port lines selected outside concurrent compare");

   a_conc_idle: assert property (!conc_en |=>
      $stable(pins_out.port5_val))
      else $error("port lines moved outside concurrent compare");

   a_pin_capture: assert property (s_pin_edge |=> ##1
      cmp_q == $past(timer2_count_in))
      else $error("pin edge capture did not latch timer");

endmodule : ccu4_compare

// ---- verif/ccu4_actuator.sv ----
// Actuator-side model: levels seen on the nine compare lines
`timescale 1ns/1ps
module ccu4_actuator
   import ccu4_pkg::*;
(
   input wire ccu4_pins_t pins_in,
   input wire logic [7:0] port5_latch_in,
   output logic [8:0] lines_out
);
   // Unselected lines show the ordinary port latch
   assign lines_out = {pins_in.cc4_pin, (pins_in.port5_val & pins_in.port5_sel) |
      (port5_latch_in & ~pins_in.port5_sel)};
endmodule : ccu4_actuator

// ---- verif/ccu4_compare_test.sv ----
// Self-checking bench for the channel-four compare unit
`timescale 1ns/1ps
module ccu4_compare_test;
   import ccu4_pkg::*;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} ccu4_row_t;
   logic clk_sys_in, rst_in, wr_in, rd_in, timer2_ovf_in, p14_latch_in;
   logic cc4_pin_in, cap_rising_in, port5_mode2_out;
   logic [7:0] addr_in, wdata_in, rdata_out, port5_latch_in, rv, exp_val, mask;
   logic [15:0] timer2_count_in;
   logic [8:0] lines;
   ccu4_pins_t pins_out;
   int n_mismatch = 0;
   int comparisons = 0;
   // Mode bit forced only where lo select is written as 1
   ccu4_row_t rows [6] = '{'{8'hC9, 8'h09, 8'h0B}, '{8'hC9, 8'h02, 8'h02},
      '{8'hC9, 8'h81, 8'h83}, '{8'hC9, 8'h70, 8'h70}, '{8'h55, 8'hFF, 8'h00},
      '{8'hCA, 8'h5A, 8'h5A}};
   ccu4_compare dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .timer2_count_in(timer2_count_in), .timer2_ovf_in(timer2_ovf_in),
      .p14_latch_in(p14_latch_in), .port5_latch_in(port5_latch_in),
      .cc4_pin_in(cc4_pin_in), .cap_rising_in(cap_rising_in), .pins_out(pins_out),
      .port5_mode2_out(port5_mode2_out));
   ccu4_actuator act (.pins_in(pins_out), .port5_latch_in(port5_latch_in), .lines_out(lines));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      #1 rv = rdata_out;
   endtask : rd
   task automatic cmp(input string s, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask : cmp
   // Timer leaves the value first, so equality is a fresh edge
   task automatic fire(input logic [7:0] lat, input logic p);
      @(posedge clk_sys_in);
      timer2_count_in <= 16'h0000;
      port5_latch_in <= lat;
      p14_latch_in <= p;
      repeat (3) @(posedge clk_sys_in);
      timer2_count_in <= 16'h1234;
      repeat (3) @(posedge clk_sys_in);
      #1;
   endtask : fire
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys_in = 1'b0;
      forever #4 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      n_mismatch++;
      wrap_up();
   end
   initial begin
      {rst_in, wr_in, rd_in, timer2_ovf_in, p14_latch_in, cc4_pin_in} = 6'h20;
      {addr_in, wdata_in, port5_latch_in, timer2_count_in, cap_rising_in} = '0;
      exp_val = 8'h00;
      repeat (20) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      rd(8'hC9);
      cmp("cfg reset", 16'h0000, {8'h00, rv});
      cmp("pins reset", 16'h0000, {15'h0000, pins_out.cc4_pin});
      $display("test reset done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a);
         cmp("reg read", {8'h00, rows[i].e}, {8'h00, rv});
      end
      $display("test registers done");
      wr(8'hCA, 8'h34);
      wr(8'hCB, 8'h12);
      wr(8'hC9, 8'h8A);
      repeat (2) @(posedge clk_sys_in);
      #1 cmp("mode2 flag", 16'h0001, {15'h0000, port5_mode2_out});
      wr(8'hC9, 8'h08);
      fire(8'h00, 1'b0);
      cmp("mode0 set", 16'h0001, {15'h0000, lines[8]});
      @(posedge clk_sys_in);
      timer2_ovf_in <= 1'b1;
      @(posedge clk_sys_in);
      timer2_ovf_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      #1 cmp("mode0 clear", 16'h0000, {15'h0000, lines[8]});
      wr(8'hC9, 8'h0A);
      fire(8'h00, 1'b1);
      cmp("mode1 high", 16'h0001, {15'h0000, lines[8]});
      fire(8'h00, 1'b0);
      cmp("mode1 low", 16'h0000, {15'h0000, lines[8]});
      wr(8'hC9, 8'h00);
      fire(8'h00, 1'b1);
      cmp("disabled pin", 16'h0000, {15'h0000, lines[8]});
      $display("test modes done");
      for (int n = 0; n < 8; n++) begin
         mask = 8'hFF >> (7 - n);
         wr(8'hC9, {1'b0, 3'(n), 4'h9});
         fire(n[0] ? 8'hFF : 8'h00, n[0]);
         exp_val = (exp_val & ~mask) | ((n[0] ? 8'hFF : 8'h00) & mask);
         cmp("p5 sel", {8'h00, mask}, {8'h00, pins_out.port5_sel});
         cmp("p5 val", {8'h00, exp_val}, {8'h00, pins_out.port5_val});
         cmp("cc4 pin", {15'h0000, n[0]}, {15'h0000, lines[8]});
         cmp("p5 lines", {8'h00, n[0] ? 8'hFF : 8'h00}, {8'h00, lines[7:0]});
      end
      $display("test concurrent done");
      wr(8'hC9, 8'h0C);
      timer2_count_in <= 16'h00C3;
      wr(8'hCA, 8'h00);
      repeat (2) @(posedge clk_sys_in);
      rd(8'hCA);
      cmp("write capture", 16'h00C3, {8'h00, rv});
      wr(8'hC9, 8'h04);
      cap_rising_in <= 1'b1;
      timer2_count_in <= 16'h0177;
      repeat (3) @(posedge clk_sys_in);
      cc4_pin_in <= 1'b1;
      repeat (5) @(posedge clk_sys_in);
      rd(8'hCA);
      cmp("pin capture lo", 16'h0077, {8'h00, rv});
      rd(8'hCB);
      cmp("pin capture hi", 16'h0001, {8'h00, rv});
      $display("test capture done");
      wrap_up();
   end
endmodule : ccu4_compare_test
